//--- rtl/multifunction_timer.sv
/*
 * Multifunction timer top: one A-type timer (timer, event, one-shot, PWM),
 * one B-type unit, register port, interrupt status and mask.
 * Assumes event pins are asynchronous and software is the only bus master.
 */
`timescale 1ns/1ps
module multifunction_timer #(
	parameter int PRESCALE = tmr_pkg::PRESCALE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic timer_a_event_pin_i,
	input wire logic timer_b_event_pin_i,
	output logic timer_a_output_pin_o,
	output logic irq_o
);
	import tmr_pkg::*;

	typedef struct packed {
		a_mode_t a_mode;
		logic a_up;
		logic a_free;
		logic a_start;
		logic a_os_active;
		logic a_pin;
		logic [15:0] a_cnt;
		logic [15:0] a_rld;
		logic b_start;
		b_mode_t b_mode;
		logic b_sel;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
		logic [7:0] presc;
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic lvl_a;
		logic lvl_b;
	} top_state_t;

	top_state_t s_q, s_d;
	tmr_b_if b_bus ();
	logic tick;
	logic a_edge;
	logic a_step;
	logic a_reload_now;
	logic a_irq_set;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic wr_ctrl;
	logic wr_amode;
	logic wr_acnt;
	logic new_start;
	a_mode_t new_mode;

	// ----------------------------------------
	// B-type unit
	// ----------------------------------------
	timer_b_unit u_timer_b (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.bus(b_bus)
	);

	// Feed the B unit from synchronised pins and register state
	always_comb begin
		b_bus.tick = tick;
		b_bus.edge_rise = (s_q.sync_b[1] == s_q.sync_b[2]) && s_q.sync_b[2] && !s_q.lvl_b;
		b_bus.edge_fall = (s_q.sync_b[1] == s_q.sync_b[2]) && !s_q.sync_b[2] && s_q.lvl_b;
		b_bus.start = s_q.b_start;
		b_bus.mode = s_q.b_mode;
		b_bus.meas_sel = s_q.b_sel;
		b_bus.wr_cnt = wr_i && (addr_i == OFF_B_COUNT);
		b_bus.wdata = wdata_i[15:0];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		wr_ctrl = wr_i && (addr_i == OFF_CTRL);
		wr_amode = wr_i && (addr_i == OFF_A_MODE);
		wr_acnt = wr_i && (addr_i == OFF_A_COUNT);
		new_start = wdata_i[CTRL_A_START];
		new_mode = a_mode_t'(wdata_i[1:0]);
		a_irq_set = 1'b0;
		a_reload_now = 1'b0;

		// Prescaler: one-cycle tick every PRESCALE clocks
		tick = (s_q.presc == 8'h00);
		s_d.presc = tick ? 8'(PRESCALE - 1) : s_q.presc - 8'h01;

		// Three-stage pin sync; a change counts once stages two and three agree
		s_d.sync_a = {s_q.sync_a[1:0], timer_a_event_pin_i};
		s_d.sync_b = {s_q.sync_b[1:0], timer_b_event_pin_i};
		if (s_q.sync_a[1] == s_q.sync_a[2]) begin
			s_d.lvl_a = s_q.sync_a[2];
		end
		if (s_q.sync_b[1] == s_q.sync_b[2]) begin
			s_d.lvl_b = s_q.sync_b[2];
		end
		a_edge = (s_q.sync_a[1] == s_q.sync_a[2]) && s_q.sync_a[2] && !s_q.lvl_a;

		// A counting; one-shot only counts while its shot is active
		case (s_q.a_mode)
			A_EVENT: a_step = a_edge;
			A_ONESHOT: a_step = tick && s_q.a_os_active;
			default: a_step = tick;
		endcase
		if (s_q.a_start && a_step) begin
			if (s_q.a_mode == A_EVENT && s_q.a_up) begin
				if (s_q.a_cnt == ALL_ONES) begin
					s_d.a_cnt = s_q.a_free ? ALL_ZEROS : s_q.a_rld;
					a_reload_now = 1'b1;
					a_irq_set = 1'b1;
				end else begin
					s_d.a_cnt = s_q.a_cnt + 16'h0001;
				end
			end else if (s_q.a_cnt == ALL_ZEROS) begin
				// Free run wraps instead of reloading, so software must rewrite after stop
				s_d.a_cnt = (s_q.a_mode == A_EVENT && s_q.a_free) ? ALL_ONES : s_q.a_rld;
				a_reload_now = 1'b1;
				case (s_q.a_mode)
					A_ONESHOT: begin
						s_d.a_pin = 1'b0;
						s_d.a_os_active = 1'b0;
						a_irq_set = 1'b1;
					end
					A_PWM: begin
						s_d.a_pin = !s_q.a_pin;
						a_irq_set = s_q.a_pin;
					end
					default: a_irq_set = 1'b1;
				endcase
			end else begin
				s_d.a_cnt = s_q.a_cnt - 16'h0001;
			end
		end

		// Count register write: reload always, counter too while halted
		if (wr_acnt) begin
			s_d.a_rld = wdata_i[15:0];
			if (!s_q.a_start) begin
				s_d.a_cnt = wdata_i[15:0];
			end
		end

		// Start flag edges
		if (wr_ctrl) begin
			s_d.a_start = new_start;
			s_d.b_start = wdata_i[CTRL_B_START];
			if (new_start && !s_q.a_start
				&& (s_q.a_mode == A_ONESHOT || s_q.a_mode == A_PWM)) begin
				s_d.a_cnt = s_q.a_rld;
				s_d.a_pin = 1'b1;
				s_d.a_os_active = (s_q.a_mode == A_ONESHOT);
			end
			if (!new_start && s_q.a_start) begin
				if (s_q.a_mode == A_ONESHOT && s_q.a_os_active) begin
					s_d.a_cnt = s_q.a_rld;
					s_d.a_pin = 1'b0;
					s_d.a_os_active = 1'b0;
					a_irq_set = 1'b1;
				end else if (s_q.a_mode == A_PWM) begin
					// A low output is already idle: no edge and no request
					s_d.a_pin = 1'b0;
					a_irq_set = a_irq_set | s_q.a_pin;
				end
			end
		end

		// Mode selection; a move from timer or event mode into one-shot or PWM raises a request
		if (wr_amode) begin
			s_d.a_mode = new_mode;
			s_d.a_up = wdata_i[A_UP_BIT];
			s_d.a_free = wdata_i[A_FREE_BIT];
			if ((s_q.a_mode == A_TIMER || s_q.a_mode == A_EVENT)
				&& (new_mode == A_ONESHOT || new_mode == A_PWM)) begin
				a_irq_set = 1'b1;
			end
		end
		if (wr_i && addr_i == OFF_B_MODE) begin
			s_d.b_mode = b_mode_t'(wdata_i[1:0]);
			s_d.b_sel = wdata_i[B_SEL_BIT];
		end
		if (wr_i && addr_i == OFF_IRQ_MASK) begin
			s_d.irq_mask = wdata_i[1:0];
		end

		// Sticky status, write one to clear; a same-cycle set wins
		irq_set = {b_bus.irq_pulse, a_irq_set};
		irq_clr = (wr_i && addr_i == OFF_IRQ_STAT) ? wdata_i[1:0] : 2'b00;
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

		// Read data valid the cycle after the strobe only
		s_d.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				OFF_CTRL: s_d.rdata = {30'h0000_0000, s_q.b_start, s_q.a_start};
				OFF_A_MODE: s_d.rdata = {28'h000_0000, s_q.a_free, s_q.a_up, s_q.a_mode};
				OFF_A_COUNT: begin
					if (a_reload_now && s_q.a_mode == A_EVENT) begin
						s_d.rdata = {16'h0000, s_q.a_up ? ALL_ZEROS : ALL_ONES};
					end else begin
						s_d.rdata = {16'h0000, s_q.a_cnt};
					end
				end
				OFF_B_MODE: s_d.rdata = {29'h0000_0000, s_q.b_sel, s_q.b_mode};
				OFF_B_COUNT: s_d.rdata = {16'h0000, b_bus.rd_val};
				OFF_IRQ_STAT: s_d.rdata = {30'h0000_0000, s_q.irq_stat};
				OFF_IRQ_MASK: s_d.rdata = {30'h0000_0000, s_q.irq_mask};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s_q <= '{a_mode: A_TIMER, b_mode: B_TIMER, a_cnt: CNT_RESET, a_rld: CNT_RESET,
				default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign timer_a_output_pin_o = s_q.a_pin;
	assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_a_live_read;
		@(posedge core_clk_i) disable iff (reset_i)
		(rd_i && addr_i == OFF_A_COUNT && s_q.a_mode == A_TIMER)
			|=> (rdata_o[15:0] == $past(s_q.a_cnt));
	endproperty
	a_a_live_read: assert property (p_a_live_read) else $error("A live read mismatch");

	property p_a_halt_write;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_acnt && !s_q.a_start && !wr_ctrl) |=> (s_q.a_cnt == $past(wdata_i[15:0]));
	endproperty
	a_a_halt_write: assert property (p_a_halt_write) else $error("A halted write lost");

	property p_a_evt_reload_read;
		@(posedge core_clk_i) disable iff (reset_i)
		(rd_i && addr_i == OFF_A_COUNT && s_q.a_mode == A_EVENT && a_reload_now)
			|=> (rdata_o == (s_q.a_up ? 32'h0000_0000 : 32'h0000_ffff));
	endproperty
	a_a_evt_reload_read: assert property (p_a_evt_reload_read) else $error("A reload read");

	property p_a_os_stop;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_ctrl && !new_start && s_q.a_start && s_q.a_mode == A_ONESHOT && s_q.a_os_active
			&& !wr_acnt) |=> (!timer_a_output_pin_o && s_q.irq_stat[IRQ_A]
			&& s_q.a_cnt == $past(s_q.a_rld));
	endproperty
	a_a_os_stop: assert property (p_a_os_stop) else $error("One-shot stop wrong");

	property p_a_mode_os;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_amode && new_mode == A_ONESHOT && s_q.a_mode inside {A_TIMER, A_EVENT})
			|=> s_q.irq_stat[IRQ_A];
	endproperty
	a_a_mode_os: assert property (p_a_mode_os) else $error("One-shot select no request");

	property p_a_mode_pwm;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_amode && new_mode == A_PWM && s_q.a_mode inside {A_TIMER, A_EVENT})
			|=> s_q.irq_stat[IRQ_A] && s_q.a_mode == A_PWM;
	endproperty
	a_a_mode_pwm: assert property (p_a_mode_pwm) else $error("PWM select no request");

	property p_a_pwm_stop_high;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_ctrl && !new_start && s_q.a_start && s_q.a_mode == A_PWM && s_q.a_pin)
			|=> (!timer_a_output_pin_o && s_q.irq_stat[IRQ_A] && !s_q.a_start);
	endproperty
	a_a_pwm_stop_high: assert property (p_a_pwm_stop_high) else $error("PWM high stop");

	property p_a_pwm_stop_low;
		@(posedge core_clk_i) disable iff (reset_i)
		(wr_ctrl && !new_start && s_q.a_start && s_q.a_mode == A_PWM && !s_q.a_pin
			&& !s_q.irq_stat[IRQ_A]) |=> (!timer_a_output_pin_o && !s_q.irq_stat[IRQ_A])[*2];
	endproperty
	a_a_pwm_stop_low: assert property (p_a_pwm_stop_low) else $error("PWM low stop");

	property p_a_underflow;
		@(posedge core_clk_i) disable iff (reset_i)
		(s_q.a_mode == A_TIMER && s_q.a_start && tick && s_q.a_cnt == ALL_ZEROS && !wr_i)
			|=> (s_q.a_cnt == $past(s_q.a_rld) && s_q.irq_stat[IRQ_A]);
	endproperty
	a_a_underflow: assert property (p_a_underflow) else $error("A underflow no reload");

endmodule // multifunction_timer

//--- rtl/tmr_pkg.sv
/*
 * Constants, register map and mode types shared by the multifunction timer block.
 * Assumes one clock, a synchronous active-high reset and a software master on a plain port.
 */
// Notes on behaviour
// - Timer A count reads in timer mode return the live counter value.
// - Timer A count written while halted reads back until counting resumes.
// - Event-mode read at reload returns all ones on underflow, zeros on overflow.
// - One-shot stop mid-count: halt, reload, output low, raise request.
// - Selecting one-shot from timer or event mode raises the request.
// - Selecting PWM from timer or event mode raises the request.
// - PWM stop while output high: halt, force low, raise request.
// - PWM stop while output low: halt, stay low, no request.
// - Timer B in timer or event mode reads live count, all ones at reload, written value when halted.
// - Changing measurement select after start in measurement mode raises the timer B request.
// - First measurement edge after start loads reload register without request.
package tmr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_A_MODE = 8'h04;
	localparam logic [7:0] OFF_A_COUNT = 8'h08;
	localparam logic [7:0] OFF_B_MODE = 8'h0c;
	localparam logic [7:0] OFF_B_COUNT = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_A_START = 0;
	localparam int CTRL_B_START = 1;
	localparam int A_UP_BIT = 2;
	localparam int A_FREE_BIT = 3;
	localparam int B_SEL_BIT = 2;
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;

	// ----------------------------------------
	// Values and counts
	// ----------------------------------------
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RESET = 16'hffff;
	localparam logic [15:0] ALL_ONES = 16'hffff;
	localparam logic [15:0] ALL_ZEROS = 16'h0000;
	localparam int PRESCALE_CYCLES = 4;

	typedef enum logic [1:0] {A_TIMER, A_EVENT, A_ONESHOT, A_PWM} a_mode_t;
	typedef enum logic [1:0] {B_TIMER, B_EVENT, B_MEASURE, B_SPARE} b_mode_t;

endpackage

//--- rtl/tmr_b_if.sv
/*
 * Carrier between the timer top and its B-type counter unit.
 * Assumes both ends share core_clk_i; all signals are same-domain.
 */
`timescale 1ns/1ps
interface tmr_b_if;
	import tmr_pkg::*;
	logic tick;
	logic edge_rise;
	logic edge_fall;
	logic start;
	b_mode_t mode;
	logic meas_sel;
	logic wr_cnt;
	logic [15:0] wdata;
	logic [15:0] rd_val;
	logic irq_pulse;

	modport ctl (output tick, edge_rise, edge_fall, start, mode, meas_sel, wr_cnt, wdata,
		input rd_val, irq_pulse);
	modport unit (input tick, edge_rise, edge_fall, start, mode, meas_sel, wr_cnt, wdata,
		output rd_val, irq_pulse);
endinterface

//--- rtl/timer_b_unit.sv
/*
 * B-type 16-bit timer: timer, event counter, pulse period / width measurement.
 * Assumes edges and ticks arrive already synchronised as one-cycle pulses.
 */
`timescale 1ns/1ps
module timer_b_unit (
	input wire logic core_clk_i,
	input wire logic reset_i,
	tmr_b_if.unit bus
);
	import tmr_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] rld;
		logic run;
		logic sel;
		logic first_pend;
	} b_state_t;

	b_state_t s_q, s_d;
	logic reload_now;
	logic eff_edge;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		reload_now = 1'b0;
		bus.irq_pulse = 1'b0;
		eff_edge = bus.meas_sel ? (bus.edge_rise | bus.edge_fall) : bus.edge_rise;
		case (bus.mode)
			B_TIMER, B_EVENT: begin
				if (bus.wr_cnt) begin
					s_d.rld = bus.wdata;
					if (!bus.start) begin
						s_d.cnt = bus.wdata;
					end
				end
				if (bus.start && (bus.mode == B_TIMER ? bus.tick : bus.edge_rise)) begin
					if (s_q.cnt == ALL_ZEROS) begin
						s_d.cnt = bus.wr_cnt ? bus.wdata : s_q.rld;
						reload_now = 1'b1;
						bus.irq_pulse = 1'b1;
					end else begin
						s_d.cnt = s_q.cnt - 16'h0001;
					end
				end
			end
			B_MEASURE: begin
				if (bus.start && bus.tick) begin
					s_d.cnt = s_q.cnt + 16'h0001;
				end
				if (bus.start && eff_edge) begin
					// The first capture holds a partial interval, so it stays silent
					s_d.rld = s_q.cnt;
					s_d.cnt = ALL_ZEROS;
					s_d.first_pend = 1'b0;
					bus.irq_pulse = s_q.run && !s_q.first_pend;
				end
				if (bus.start && s_q.run && (bus.meas_sel != s_q.sel)) begin
					bus.irq_pulse = 1'b1;
				end
			end
			default: begin
			end
		endcase
		// An edge in the start cycle is itself the first edge, so it must not arm another
		if (bus.start && !s_q.run && !eff_edge) begin
			s_d.first_pend = 1'b1;
		end
		s_d.run = bus.start;
		s_d.sel = bus.meas_sel;
		if (bus.mode == B_MEASURE) begin
			bus.rd_val = s_q.rld;
		end else begin
			bus.rd_val = reload_now ? ALL_ONES : s_q.cnt;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s_q <= '{cnt: CNT_RESET, rld: CNT_RESET, run: 1'b0, sel: 1'b0, first_pend: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	property p_b_reload_read;
		@(posedge core_clk_i) disable iff (reset_i)
		(bus.mode != B_MEASURE && bus.start && bus.tick && bus.mode == B_TIMER
			&& s_q.cnt == ALL_ZEROS) |-> (bus.rd_val == ALL_ONES);
	endproperty
	a_b_reload_read: assert property (p_b_reload_read) else $error("B reload read not all ones");

	property p_b_sel_change;
		@(posedge core_clk_i) disable iff (reset_i)
		(bus.mode == B_MEASURE && bus.start && s_q.run && bus.meas_sel != s_q.sel)
			|-> bus.irq_pulse;
	endproperty
	a_b_sel_change: assert property (p_b_sel_change) else $error("B select change no request");

	property p_b_first_edge;
		@(posedge core_clk_i) disable iff (reset_i)
		(bus.mode == B_MEASURE && bus.start && eff_edge && s_q.first_pend
			&& bus.meas_sel == s_q.sel) |-> !bus.irq_pulse ##1 !s_q.first_pend;
	endproperty
	a_b_first_edge: assert property (p_b_first_edge) else $error("B first edge raised request");

endmodule // timer_b_unit

//--- verification/multifunction_timer_side_effects_tb.sv
/*
 * Self-checking bench for the multifunction timer: register port tasks, mode side effects,
 * stop behaviour, read-back rules and the interrupt path.
 * Assumes the design top and its package compile first; the bench is the only bus master.
 */
`timescale 1ns/1ps
module multifunction_timer_side_effects_tb;
	import tmr_pkg::*;

	// ----------------------------------------
	// Signals and counters
	// ----------------------------------------
	localparam int PRESCALE_TB = 1;
	localparam int CYCLE_LIMIT = 6000;
	logic core_clk_i, reset_i, wr_i, rd_i, irq_o;
	logic timer_a_event_pin_i, timer_b_event_pin_i, timer_a_output_pin_o;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, v;
	int mismatches, tests_run, cycles;

	// Prescale of one keeps every count short and the run brief
	multifunction_timer #(.PRESCALE(PRESCALE_TB)) dut (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.timer_a_event_pin_i(timer_a_event_pin_i),
		.timer_b_event_pin_i(timer_b_event_pin_i),
		.timer_a_output_pin_o(timer_a_output_pin_o),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle write strobe, released on the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe, so sample it mid-cycle there
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		d = rdata_o;
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(name, d, exp);
	endtask

	// Pulses are long enough to pass the three-flop sync and agree filter
	task automatic pulse(input bit on_b);
		@(posedge core_clk_i);
		if (on_b) timer_b_event_pin_i <= 1'b1;
		else timer_a_event_pin_i <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		timer_b_event_pin_i <= 1'b0;
		timer_a_event_pin_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
	endtask

	task automatic complete_run;
		$display("Checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end

	// A stuck wait loop must still reach the verdict
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT) begin
			mismatches++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		timer_a_event_pin_i = 1'b0;
		timer_b_event_pin_i = 1'b0;
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		repeat (8) @(posedge core_clk_i);
		reset_i <= 1'b0;
		// Reset state and an unmapped place
		rchk("a count reset", OFF_A_COUNT, 32'h0000_ffff);
		rchk("b count reset", OFF_B_COUNT, 32'h0000_ffff);
		rchk("status reset", OFF_IRQ_STAT, 32'h0);
		rchk("unmapped read", 8'h40, 32'h0);
		chk("pin reset", 32'(timer_a_output_pin_o), 32'h0);
		// Timer and event mode into both pulse modes raise the request
		for (int s = 0; s < 2; s++) begin
			for (int d = 2; d < 4; d++) begin
				wr(OFF_A_MODE, 32'(s));
				wr(OFF_IRQ_STAT, 32'h3);
				wr(OFF_A_MODE, 32'(d));
				rchk("mode select request", OFF_IRQ_STAT, 32'h1);
			end
		end
		// Interrupt line follows status and mask
		repeat (2) @(posedge core_clk_i);
		chk("irq masked", 32'(irq_o), 32'h0);
		wr(OFF_IRQ_MASK, 32'h3);
		repeat (2) @(posedge core_clk_i);
		chk("irq unmasked", 32'(irq_o), 32'h1);
		wr(OFF_IRQ_STAT, 32'h3);
		repeat (2) @(posedge core_clk_i);
		chk("irq cleared", 32'(irq_o), 32'h0);
		rchk("status cleared", OFF_IRQ_STAT, 32'h0);
		// One-shot stopped mid-count
		wr(OFF_A_MODE, 32'(A_ONESHOT));
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_A_COUNT, 32'h0000_0100);
		wr(OFF_CTRL, 32'h1);
		repeat (10) @(posedge core_clk_i);
		chk("one-shot pin high", 32'(timer_a_output_pin_o), 32'h1);
		wr(OFF_CTRL, 32'h0);
		@(negedge core_clk_i);
		chk("one-shot stop pin", 32'(timer_a_output_pin_o), 32'h0);
		rchk("one-shot stop status", OFF_IRQ_STAT, 32'h1);
		rchk("one-shot stop reload", OFF_A_COUNT, 32'h0000_0100);
		chk("one-shot irq", 32'(irq_o), 32'h1);
		// PWM stopped while high
		wr(OFF_A_MODE, 32'(A_PWM));
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_A_COUNT, 32'h0000_0040);
		wr(OFF_CTRL, 32'h1);
		repeat (6) @(posedge core_clk_i);
		chk("pwm pin high", 32'(timer_a_output_pin_o), 32'h1);
		wr(OFF_CTRL, 32'h0);
		@(negedge core_clk_i);
		chk("pwm stop high pin", 32'(timer_a_output_pin_o), 32'h0);
		rchk("pwm stop high status", OFF_IRQ_STAT, 32'h1);
		// PWM stopped while low: no request may appear
		wr(OFF_CTRL, 32'h1);
		repeat (4) @(posedge core_clk_i);
		for (int i = 0; i < 400 && timer_a_output_pin_o !== 1'b0; i++) @(posedge core_clk_i);
		chk("pwm low phase", 32'(timer_a_output_pin_o), 32'h0);
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_CTRL, 32'h0);
		repeat (3) @(posedge core_clk_i);
		chk("pwm stop low pin", 32'(timer_a_output_pin_o), 32'h0);
		rchk("pwm stop low status", OFF_IRQ_STAT, 32'h0);
		// Timer mode: live count, then underflow raises the request
		wr(OFF_A_MODE, 32'(A_TIMER));
		wr(OFF_A_COUNT, 32'h0000_0010);
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_A_COUNT, v);
		chk("a live count", v, 32'h0000_000f);
		repeat (40) @(posedge core_clk_i);
		rchk("a underflow status", OFF_IRQ_STAT, 32'h1);
		wr(OFF_CTRL, 32'h0);
		// Free-running event counter: two edges, then rewrite after stopping
		wr(OFF_A_MODE, 32'(A_EVENT) | (32'h1 << A_FREE_BIT));
		wr(OFF_A_COUNT, 32'h0000_0005);
		wr(OFF_CTRL, 32'h1);
		pulse(1'b0);
		pulse(1'b0);
		rchk("a event count", OFF_A_COUNT, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_A_COUNT, 32'h0000_1234);
		rchk("a halted write", OFF_A_COUNT, 32'h0000_1234);
		// Event reload read: the read is timed onto the edge that reloads the counter
		for (int up = 0; up < 2; up++) begin
			wr(OFF_A_MODE, 32'(A_EVENT) | (32'(up) << A_UP_BIT));
			wr(OFF_A_COUNT, up ? 32'h0000_ffff : 32'h0000_0000);
			wr(OFF_CTRL, 32'h1);
			@(posedge core_clk_i);
			timer_a_event_pin_i <= 1'b1;
			repeat (2) @(posedge core_clk_i);
			rd(OFF_A_COUNT, v);
			chk("a event reload read", v, up ? 32'h0000_0000 : 32'h0000_ffff);
			wr(OFF_CTRL, 32'h0);
			timer_a_event_pin_i <= 1'b0;
		end
		// Timer B: halted write reads back, then counts live
		wr(OFF_B_COUNT, 32'h0000_0abc);
		rchk("b halted write", OFF_B_COUNT, 32'h0000_0abc);
		wr(OFF_CTRL, 32'h2);
		repeat (4) @(posedge core_clk_i);
		rd(OFF_B_COUNT, v);
		chk("b live count", v, 32'h0000_0ab7);
		wr(OFF_CTRL, 32'h0);
		// Timer B read on the reload edge returns all ones
		wr(OFF_B_COUNT, 32'h0000_0002);
		wr(OFF_CTRL, 32'h2);
		@(posedge core_clk_i);
		rd(OFF_B_COUNT, v);
		chk("b reload read", v, 32'h0000_ffff);
		wr(OFF_CTRL, 32'h0);
		// Measurement: first edge silent, second edge requests
		wr(OFF_B_MODE, 32'(B_MEASURE));
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_CTRL, 32'h2);
		pulse(1'b1);
		rchk("first edge status", OFF_IRQ_STAT, 32'h0);
		pulse(1'b1);
		rchk("second edge status", OFF_IRQ_STAT, 32'h2);
		wr(OFF_IRQ_STAT, 32'h3);
		wr(OFF_B_MODE, 32'(B_MEASURE) | (32'h1 << B_SEL_BIT));
		rchk("select change status", OFF_IRQ_STAT, 32'h2);
		complete_run();
	end
endmodule // multifunction_timer_side_effects_tb
